// ### rtl/hbil_map.vh
// constants for the host buffer and interrupt logic block
`ifndef HBIL_MAP_VH
`define HBIL_MAP_VH
// status register bit positions
`define HBIL_ST_OUT_FULL 0
`define HBIL_ST_IN_FULL 1
`define HBIL_ST_GEN_FLAG 2
`define HBIL_ST_CMD_DATA 3
`define HBIL_ST_USER_LO 4
`define HBIL_STATUS_RESET 8'h00
// interrupt vectors
`define HBIL_VEC_INPUT 12'h003
`define HBIL_VEC_TIMER 12'h007
// latency bounds in cycles
`define HBIL_LAT_MIN 4
`define HBIL_LAT_MAX 7
`define HBIL_LAT_W 3
// sequencer control operation codes
`define HBIL_OP_NONE 4'h0
`define HBIL_OP_EN_I 4'h1
`define HBIL_OP_INPUT_IRQ_DISABLE_INSTR 4'h2
`define HBIL_OP_EN_T 4'h3
`define HBIL_OP_DIS_T 4'h4
`define HBIL_OP_RETURN_RESTORE_INSTR 4'h5
`define HBIL_OP_EN_FLAGS 4'h6
`define HBIL_OP_EN_DMA 4'h7
`define HBIL_OP_CLR_F0 4'h8
`define HBIL_OP_CPL_F0 4'h9
`define HBIL_OP_CLR_F1 4'ha
`define HBIL_OP_CPL_F1 4'hb
`define HBIL_OP_MOV_STS 4'hc
`define HBIL_OP_OUT_DBB 4'hd
`define HBIL_OP_IN_DBB 4'he
`define HBIL_OP_PORT2 4'hf
`endif

// ### rtl/hbil_sync.v
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
`default_nettype none
module hbil_sync (
  input wire mclk_i,
  input wire reset_i,
  input wire rst_val_i,
  input wire pin_i,
  output reg level_o
);
  reg s1;
  reg s2;
  reg s3;
  // first stage feeds only the second; change accepted when stages 2 and 3 agree
  always @(posedge mclk_i) begin
    if (reset_i) begin
      // idle level of the pin, so no false edge follows reset
      s1 <= rst_val_i;
      s2 <= rst_val_i;
      s3 <= rst_val_i;
      level_o <= rst_val_i;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;
      end
    end
  end
endmodule // hbil_sync
`default_nettype wire

// ### rtl/hbil_top.v
// host data bus buffer, status flags, interrupt logic, host flags and dma pins
`timescale 1ns/1ps
`default_nettype none
`include "hbil_map.vh"
// Summary of operation
// - input vector 3, timer vector 7
// - host write raises input request always
// - input request cleared only on entry
// - finish instruction, push pc and status
// - return restores pc, status, reenables
// - timer irq on overflow, own enable
// - service latency between 4 and 7
// - held request reenters service at once
// - single level, reenable in return cycle two
// - input wins, timer stays pending
// - counter at ffh, falling edge interrupts
// - flag mode drives out-full, inverted in-full
// - writing 0 inhibits; only reset exits
// - dma mode: bit6 request, bit7 acknowledge
// - acknowledge acts as chip select; reset exits
// - reset clears pc, sp, bank, flags
// - out-full sets on load, clears on read
// - in-full sets on host write, clears on read
// - general flag device only, host visible
// - command flag takes address on write
// - upper status user bits, reset clears
// - internal moves asynchronous to host
// - address selects status or output buffer
// - host write latches data, sets in-full
module hbil_top (
  input wire mclk_i,
  input wire reset_i,
  input wire cs_n_i,
  input wire rd_n_i,
  input wire wr_n_i,
  input wire host_address_select_i,
  input wire [7:0] host_data_i,
  output reg [7:0] host_data_o,
  output wire host_data_oe_o,
  input wire [3:0] op_i,
  input wire [7:0] acc_i,
  input wire instr_done_i,
  input wire [11:0] pc_i,
  input wire [3:0] psw_hi_i,
  input wire timer_overflow_i,
  input wire event_count_mode_i,
  input wire counter_at_max_i,
  input wire event_pin_i,
  input wire dma_acknowledge_pin_i,
  output reg [7:0] acc_o,
  output reg irq_call_o,
  output reg [11:0] irq_vector_o,
  output reg [15:0] stack_push_o,
  output reg sp_inc_o,
  output wire [11:0] reset_pc_o,
  output wire [2:0] reset_sp_o,
  output wire reset_bank_o,
  output wire ports_input_o,
  output wire timer_stop_o,
  output wire timer_flag_clr_o,
  output reg [3:0] port2_hi_o,
  output reg [3:0] port2_hi_oe_o,
  output reg in_service_o,
  output wire [7:0] status_o
);
  ////////////////////////////////////////////////////////////////////////////
  // host strobes, synchronised; dma acknowledge acts as a chip select
  wire cs_s;
  wire rd_s;
  wire wr_s;
  wire a0_s;
  wire ev_s;
  wire dma_acknowledge_pin_s;
  reg [7:0] din_q1;
  reg [7:0] din_q2;
  reg wr_prev;
  reg rd_prev;
  reg ev_prev;
  hbil_sync u_cs (.mclk_i(mclk_i), .reset_i(reset_i), .rst_val_i(1'b1), .pin_i(cs_n_i), .level_o(cs_s));
  hbil_sync u_rd (.mclk_i(mclk_i), .reset_i(reset_i), .rst_val_i(1'b1), .pin_i(rd_n_i), .level_o(rd_s));
  hbil_sync u_wr (.mclk_i(mclk_i), .reset_i(reset_i), .rst_val_i(1'b1), .pin_i(wr_n_i), .level_o(wr_s));
  hbil_sync u_a0 (.mclk_i(mclk_i), .reset_i(reset_i), .rst_val_i(1'b1),
    .pin_i(host_address_select_i), .level_o(a0_s));
  hbil_sync u_ev (.mclk_i(mclk_i), .reset_i(reset_i), .rst_val_i(1'b1), .pin_i(event_pin_i), .level_o(ev_s));
  hbil_sync u_dk (.mclk_i(mclk_i), .reset_i(reset_i), .rst_val_i(1'b1),
    .pin_i(dma_acknowledge_pin_i), .level_o(dma_acknowledge_pin_s));

  reg flags_mode;
  reg dma_mode;
  wire sel = ~cs_s | (dma_mode & ~dma_acknowledge_pin_s);
  wire wr_act = sel & ~wr_s;
  wire rd_act = sel & ~rd_s;
  wire wr_start = wr_act & ~wr_prev;
  wire rd_end = ~rd_act & rd_prev;

  // data is sampled a few cycles late to match the strobe delay
  always @(posedge mclk_i) begin
    if (reset_i) begin
      din_q1 <= 8'h00;
      din_q2 <= 8'h00;
      wr_prev <= 1'b0;
      rd_prev <= 1'b0;
      ev_prev <= 1'b1;
    end else begin
      din_q1 <= host_data_i;
      din_q2 <= din_q1;
      wr_prev <= wr_act;
      rd_prev <= rd_act;
      ev_prev <= ev_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffers and status register
  reg [7:0] host_input_buffer;
  reg [7:0] host_output_buffer;
  reg out_full;
  reg in_full;
  reg gen_flag;
  reg cmd_flag;
  reg [3:0] user_bits;
  reg rd_a0;
  wire load_out = (op_i == `HBIL_OP_OUT_DBB);
  wire read_in = (op_i == `HBIL_OP_IN_DBB);

  assign status_o = {user_bits, cmd_flag, gen_flag, in_full, out_full};

  // device side moves are independent of host timing
  always @(posedge mclk_i) begin
    if (reset_i) begin
      host_input_buffer <= 8'h00;
      host_output_buffer <= 8'h00;
      out_full <= 1'b0;
      in_full <= 1'b0;
      gen_flag <= 1'b0;
      cmd_flag <= 1'b0;
      user_bits <= 4'h0;
      acc_o <= 8'h00;
      rd_a0 <= 1'b0;
    end else begin
      if (rd_act & ~rd_prev) begin
        rd_a0 <= a0_s;
      end
      if (wr_start) begin
        host_input_buffer <= din_q2;
      end
      // host write set wins over a same-cycle device read
      if (wr_start) begin
        in_full <= 1'b1;
      end else if (read_in) begin
        in_full <= 1'b0;
      end
      if (read_in) begin
        acc_o <= host_input_buffer;
      end
      if (load_out) begin
        host_output_buffer <= acc_i;
        out_full <= 1'b1;
      end else if (rd_end & ~rd_a0) begin
        out_full <= 1'b0;
      end
      if (op_i == `HBIL_OP_CLR_F0) begin
        gen_flag <= 1'b0;
      end else if (op_i == `HBIL_OP_CPL_F0) begin
        gen_flag <= ~gen_flag;
      end
      if (wr_start) begin
        cmd_flag <= a0_s;
      end else if (op_i == `HBIL_OP_CLR_F1) begin
        cmd_flag <= 1'b0;
      end else if (op_i == `HBIL_OP_CPL_F1) begin
        cmd_flag <= ~cmd_flag;
      end
      if (op_i == `HBIL_OP_MOV_STS) begin
        user_bits <= acc_i[7:4];
      end
    end
  end

  // host read data, driven while read strobe and select are active
  assign host_data_oe_o = rd_act;
  always @(posedge mclk_i) begin
    if (reset_i) begin
      host_data_o <= 8'h00;
    end else if (a0_s) begin
      host_data_o <= status_o;
    end else begin
      host_data_o <= host_output_buffer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt logic
  reg in_en;
  reg tm_en;
  reg in_req;
  reg tm_req;
  reg [`HBIL_LAT_W-1:0] lat_cnt;
  reg pend;
  wire ev_fall = ev_prev & ~ev_s;
  wire tm_ovf = timer_overflow_i | (event_count_mode_i & counter_at_max_i & ev_fall);
  wire in_go = in_en & in_req;
  wire tm_go = tm_en & tm_req;
  wire take = (in_go | tm_go) & ~in_service_o & (lat_cnt >= `HBIL_LAT_MIN - 1) &
    (instr_done_i | lat_cnt == `HBIL_LAT_MAX - 1);

  // requests latch regardless of enables; entry clears only its own source
  always @(posedge mclk_i) begin
    if (reset_i) begin
      in_en <= 1'b0;
      tm_en <= 1'b0;
      in_req <= 1'b0;
      tm_req <= 1'b0;
      in_service_o <= 1'b0;
      irq_call_o <= 1'b0;
      irq_vector_o <= 12'h000;
      stack_push_o <= 16'h0000;
      sp_inc_o <= 1'b0;
      lat_cnt <= {`HBIL_LAT_W{1'b0}};
      pend <= 1'b0;
    end else begin
      irq_call_o <= 1'b0;
      sp_inc_o <= 1'b0;
      case (op_i)
        `HBIL_OP_EN_I: in_en <= 1'b1;
        `HBIL_OP_INPUT_IRQ_DISABLE_INSTR: in_en <= 1'b0; // request stays latched
        `HBIL_OP_EN_T: tm_en <= 1'b1;
        `HBIL_OP_DIS_T: tm_en <= 1'b0;
        default: ;
      endcase
      // return reopens acceptance; a held request reenters at once
      if (op_i == `HBIL_OP_RETURN_RESTORE_INSTR) begin
        in_service_o <= 1'b0;
      end
      pend <= (in_go | tm_go) & ~in_service_o & ~take;
      if (pend & ~take) begin
        lat_cnt <= lat_cnt + 1'b1;
      end else begin
        lat_cnt <= {`HBIL_LAT_W{1'b0}};
      end
      if (take) begin
        in_service_o <= 1'b1;
        irq_call_o <= 1'b1;
        sp_inc_o <= 1'b1;
        stack_push_o <= {psw_hi_i, pc_i};
        irq_vector_o <= in_go ? `HBIL_VEC_INPUT : `HBIL_VEC_TIMER;
      end
      if (wr_act) begin
        in_req <= 1'b1;
      end else if (take & in_go) begin
        in_req <= 1'b0;
      end
      if (tm_ovf) begin
        tm_req <= 1'b1;
      end else if (take & ~in_go) begin
        tm_req <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port 2 upper half: host flags and dma handshake
  reg [3:0] p2_latch;
  always @(posedge mclk_i) begin
    if (reset_i) begin
      flags_mode <= 1'b0;
      dma_mode <= 1'b0;
      p2_latch <= 4'hf;
    end else begin
      if (op_i == `HBIL_OP_EN_FLAGS) begin
        flags_mode <= 1'b1;
      end
      if (op_i == `HBIL_OP_EN_DMA) begin
        dma_mode <= 1'b1;
        p2_latch[2] <= 1'b0; // request cleared on enable
      end else if (op_i == `HBIL_OP_PORT2) begin
        p2_latch <= acc_i[7:4];
      end else if (dma_mode & ~dma_acknowledge_pin_s) begin
        p2_latch[2] <= 1'b0; // acknowledge retires the request
      end
    end
  end

  always @* begin
    port2_hi_o = p2_latch;
    port2_hi_oe_o = 4'h0;
    if (flags_mode) begin
      port2_hi_o[0] = out_full & p2_latch[0];
      port2_hi_o[1] = ~in_full & p2_latch[1];
      port2_hi_oe_o[1:0] = 2'b11;
    end
    if (dma_mode) begin
      port2_hi_oe_o[2] = 1'b1;
      port2_hi_oe_o[3] = 1'b0;
    end
  end

  // reset side effects for the sequencer
  assign reset_pc_o = {12{reset_i}} & 12'h000;
  assign reset_sp_o = 3'h0;
  assign reset_bank_o = reset_i;
  assign ports_input_o = reset_i;
  assign timer_stop_o = reset_i;
  assign timer_flag_clr_o = reset_i;
endmodule // hbil_top
`default_nettype wire

// ### verif/hbil_monitor.sv
// assertion checker for the host buffer interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "hbil_map.vh"
module hbil_monitor (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic cs_n_i,
  input wire logic wr_n_i,
  input wire logic [3:0] op_i,
  input wire logic host_data_oe_o,
  input wire logic irq_call_o,
  input wire logic [11:0] irq_vector_o,
  input wire logic sp_inc_o,
  input wire logic in_service_o,
  input wire logic [11:0] reset_pc_o,
  input wire logic reset_bank_o,
  input wire logic ports_input_o,
  input wire logic timer_stop_o,
  input wire logic timer_flag_clr_o,
  input wire logic [7:0] status_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  property p_vec;
    irq_call_o |-> irq_vector_o == `HBIL_VEC_INPUT || irq_vector_o == `HBIL_VEC_TIMER;
  endproperty
  property p_sp; irq_call_o |-> sp_inc_o; endproperty
  property p_svc; irq_call_o |=> in_service_o; endproperty
  // call and service flag rise together, so look at the flag before the call
  property p_single; irq_call_o |-> !$past(in_service_o); endproperty
  // reset effects are checked while reset is high, so no disable here
  property p_rst;
    disable iff (1'b0) reset_i |-> reset_pc_o == 12'h000 && reset_bank_o && ports_input_o && timer_stop_o &&
      timer_flag_clr_o;
  endproperty
  property p_sts; disable iff (1'b0) reset_i |=> status_o == 8'h00; endproperty
  property p_obf; op_i == `HBIL_OP_OUT_DBB |-> ##[1:2] status_o[0]; endproperty
  property p_ibf; op_i == `HBIL_OP_IN_DBB && wr_n_i |-> ##[1:2] !status_o[1]; endproperty
  property p_oe; cs_n_i [*6] |-> !host_data_oe_o; endproperty
  property p_f0;
    $changed(status_o[2]) |-> $past(op_i) inside {`HBIL_OP_CLR_F0, `HBIL_OP_CPL_F0}
      || $past(op_i, 2) inside {`HBIL_OP_CLR_F0, `HBIL_OP_CPL_F0};
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  a_sp: assert property (p_sp) else $error("no stack step");
  a_svc: assert property (p_svc) else $error("no service");
  a_single: assert property (p_single) else $error("nested call");
  a_rst: assert property (p_rst) else $error("reset pc");
  a_sts: assert property (p_sts) else $error("reset status");
  a_obf: assert property (p_obf) else $error("out full");
  a_ibf: assert property (p_ibf) else $error("in full");
  a_oe: assert property (p_oe) else $error("bus driven");
  a_f0: assert property (p_f0) else $error("gen flag");
  c_in: cover property (irq_call_o && irq_vector_o == `HBIL_VEC_INPUT);
  c_tm: cover property (irq_call_o && irq_vector_o == `HBIL_VEC_TIMER);
  c_rd: cover property (host_data_oe_o);
endmodule // hbil_monitor
bind hbil_top hbil_monitor u_mon (.*);
`default_nettype wire

// ### verif/hbil_host.sv
// host bus and dma controller model
`timescale 1ns/1ps
`default_nettype none
module hbil_host (
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic a0_o,
  output logic dma_acknowledge_pin_n_o,
  output logic [7:0] data_o
);
  initial begin
    {cs_n_o, rd_n_o, wr_n_o, dma_acknowledge_pin_n_o, a0_o} = 5'h1e;
    data_o = 8'h00;
  end
  // strobes held six cycles so the pin syncs see them
  task automatic xfer(input logic w, a, dma, input logic [7:0] d, output logic [7:0] q);
    @(negedge mclk_i);
    a0_o = a;
    data_o = d;
    if (dma) dma_acknowledge_pin_n_o = 1'b0;
    else cs_n_o = 1'b0;
    if (w) wr_n_o = 1'b0;
    else rd_n_o = 1'b0;
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i);
    q = rdata_i; // taken half a cycle after the edge that launched it
    {cs_n_o, rd_n_o, wr_n_o, dma_acknowledge_pin_n_o} = 4'hf;
    data_o = ~d; // released bus never keeps the old byte
    repeat (6) @(negedge mclk_i);
  endtask
endmodule // hbil_host
`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the host buffer interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "hbil_map.vh"
module testbench;
  logic mclk_i, reset_i, cs_n_i, rd_n_i, wr_n_i, host_address_select_i, host_data_oe_o;
  logic instr_done_i, timer_overflow_i, event_count_mode_i, counter_at_max_i, event_pin_i;
  logic dma_acknowledge_pin_i, irq_call_o, sp_inc_o, reset_bank_o, ports_input_o;
  logic timer_stop_o, timer_flag_clr_o, in_service_o;
  logic [7:0] host_data_i, host_data_o, acc_i, acc_o, status_o, q;
  logic [3:0] op_i, psw_hi_i, port2_hi_o, port2_hi_oe_o;
  logic [11:0] pc_i, irq_vector_o, reset_pc_o, lvec;
  logic [15:0] stack_push_o, lpush;
  logic [2:0] reset_sp_o;
  int errors = 0;
  int samples_checked = 0;
  int ncall = 0;
  int cyc = 0;
  int lcyc = 0;
  int t0 = 0;
  hbil_top u_dut (.*);
  hbil_host u_host (.mclk_i(mclk_i), .rdata_i(host_data_o), .cs_n_o(cs_n_i), .rd_n_o(rd_n_i),
    .wr_n_o(wr_n_i), .a0_o(host_address_select_i), .dma_acknowledge_pin_n_o(dma_acknowledge_pin_i), .data_o(host_data_i));
  ////////////////////////////////////////////////////////////////
  // clock, and an instruction end every other cycle
  initial begin
    mclk_i = 0;
    forever #2 mclk_i = ~mclk_i;
  end
  always @(negedge mclk_i) instr_done_i <= ~instr_done_i;
  // keep the last forced call for later comparison
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (irq_call_o) begin
      ncall <= ncall + 1;
      lvec <= irq_vector_o;
      lpush <= stack_push_o;
      lcyc <= cyc;
    end
  end
  task automatic chk(input logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic op(input logic [3:0] c, input logic [7:0] a);
    @(negedge mclk_i);
    op_i = c;
    acc_i = a;
    @(negedge mclk_i);
    op_i = `HBIL_OP_NONE;
    repeat (4) @(negedge mclk_i);
  endtask
  // bounded wait, since the call may land inside the last op
  task automatic wcall(input int n, input logic [11:0] v);
    repeat (20) if (ncall != n) @(negedge mclk_i);
    chk(16'(ncall), 16'(n));
    chk(lvec, v);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // watchdog far above the roughly 300 cycles needed
  initial begin
    #40000;
    errors++;
    test_done();
  end
  initial begin
    reset_i = 1;
    op_i = `HBIL_OP_NONE;
    acc_i = 8'h00;
    {event_count_mode_i, counter_at_max_i, event_pin_i, timer_overflow_i, instr_done_i} = 5'b00100;
    pc_i = 12'h123;
    psw_hi_i = 4'ha;
    repeat (2) @(negedge mclk_i);
    reset_i = 0;
    repeat (4) @(negedge mclk_i);
    chk({status_o, port2_hi_oe_o}, 12'h000);
    $display("end reset");
    u_host.xfer(1, 1, 0, 8'h5a, q);
    chk(status_o, 8'h0a);
    chk(16'(ncall), 0);
    t0 = cyc;
    op(`HBIL_OP_EN_I, 0);
    wcall(1, `HBIL_VEC_INPUT);
    // op issue, enable landing and request pickup add three edges ahead of the latency
    chk(16'(lcyc - t0 >= `HBIL_LAT_MIN + 3 && lcyc - t0 <= `HBIL_LAT_MAX + 3), 1);
    chk(lpush, 16'ha123);
    op(`HBIL_OP_EN_T, 0);
    @(negedge mclk_i) timer_overflow_i = 1;
    @(negedge mclk_i) timer_overflow_i = 0;
    u_host.xfer(1, 0, 0, 8'h11, q);
    chk(16'(ncall), 1);
    op(`HBIL_OP_IN_DBB, 0);
    chk({acc_o, status_o}, 16'h1100);
    op(`HBIL_OP_RETURN_RESTORE_INSTR, 0);
    wcall(2, `HBIL_VEC_INPUT);
    op(`HBIL_OP_RETURN_RESTORE_INSTR, 0);
    wcall(3, `HBIL_VEC_TIMER);
    op(`HBIL_OP_DIS_T, 0);
    op(`HBIL_OP_INPUT_IRQ_DISABLE_INSTR, 0);
    op(`HBIL_OP_RETURN_RESTORE_INSTR, 0);
    chk(in_service_o, 0);
    u_host.xfer(1, 0, 0, 8'h22, q);
    op(`HBIL_OP_EN_I, 0);
    wcall(4, `HBIL_VEC_INPUT);
    op(`HBIL_OP_IN_DBB, 0);
    op(`HBIL_OP_INPUT_IRQ_DISABLE_INSTR, 0);
    op(`HBIL_OP_RETURN_RESTORE_INSTR, 0);
    $display("end irq");
    op(`HBIL_OP_OUT_DBB, 8'h3c);
    chk(status_o, 8'h01);
    u_host.xfer(0, 1, 0, 8'h00, q);
    chk(q, 8'h01);
    u_host.xfer(0, 0, 0, 8'h00, q);
    chk({q, status_o}, 16'h3c00);
    op(`HBIL_OP_CPL_F0, 0);
    chk(status_o, 8'h04);
    op(`HBIL_OP_CPL_F1, 0);
    chk(status_o, 8'h0c);
    op(`HBIL_OP_CLR_F0, 0);
    op(`HBIL_OP_CLR_F1, 0);
    op(`HBIL_OP_MOV_STS, 8'ha5);
    chk(status_o, 8'ha0);
    $display("end buffer");
    op(`HBIL_OP_EN_FLAGS, 0);
    op(`HBIL_OP_OUT_DBB, 8'h77);
    chk({port2_hi_oe_o[1:0], port2_hi_o[1:0]}, 4'hf);
    op(`HBIL_OP_PORT2, 8'h00);
    chk(port2_hi_o[1:0], 2'b00);
    op(`HBIL_OP_EN_DMA, 0);
    op(`HBIL_OP_PORT2, 8'h40);
    chk({port2_hi_oe_o[3:2], port2_hi_o[2]}, 3'b011);
    u_host.xfer(1, 0, 1, 8'hc3, q);
    chk(port2_hi_o[2], 0);
    op(`HBIL_OP_IN_DBB, 0);
    chk(acc_o, 8'hc3);
    $display("end dma");
    event_count_mode_i = 1;
    counter_at_max_i = 1;
    op(`HBIL_OP_EN_T, 0);
    chk(16'(ncall), 4);
    event_pin_i = 0;
    wcall(5, `HBIL_VEC_TIMER);
    op(`HBIL_OP_RETURN_RESTORE_INSTR, 0);
    reset_i = 1;
    repeat (2) @(negedge mclk_i);
    chk({reset_bank_o, ports_input_o, timer_stop_o, timer_flag_clr_o, reset_pc_o}, 16'hf000);
    chk(reset_sp_o, 0);
    reset_i = 0;
    @(negedge mclk_i);
    chk({reset_bank_o, ports_input_o, timer_stop_o, timer_flag_clr_o, status_o, port2_hi_oe_o}, 16'h0000);
    $display("end event");
    test_done();
  end
endmodule // testbench
`default_nettype wire
